// *** common/crr_exec_params.svh ***
// constants for the call, return and rotate execution block
`ifndef CRR_EXEC_PARAMS_SVH
`define CRR_EXEC_PARAMS_SVH
`define PC_WIDTH        21
`define STACK_DEPTH     31
`define STACK_PTR_WIDTH 5
`define FLAG_C          0
`define FLAG_Z          2
`define FLAG_N          4
`define ACCESS_SPLIT    8'h80
`define ACCESS_HIGH     4'hF
`define RESET_PC        21'h000000
`define RESET_WORD      8'h00
`define FILL_VALUE      8'hFF
`define PC_STEP         21'h000002
`endif

// *** common/crr_exec_pkg.sv ***
// types for the call, return and rotate execution block
package crr_exec_pkg;
  typedef enum logic [1:0] {
    EXEC_RUN  = 2'b00,
    EXEC_WAIT = 2'b01
  } exec_state_t;
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_PUSH  = 4'h1,
    OP_POP   = 4'h2,
    OP_RELATIVE_CALL = 4'h3,
    OP_RST   = 4'h4,
    OP_IRET  = 4'h5,
    OP_RLIT  = 4'h6,
    OP_RET   = 4'h7,
    OP_RLC   = 4'h8,
    OP_RLN   = 4'h9,
    OP_RRC   = 4'hA,
    OP_RRN   = 4'hB,
    OP_FILL  = 4'hC
  } op_kind_t;
endpackage

// *** rtl/return_stack_mem.sv ***
// return address stack memory with registered read data
`timescale 1ns/10ps
`include "crr_exec_params.svh"
module return_stack_mem (
  // clock
  input  wire logic                          sys_clk,
  // write port
  input  wire logic                          wrEn,
  input  wire logic [`STACK_PTR_WIDTH-1:0]   wrAddr,
  input  wire logic [`PC_WIDTH-1:0]          wrData,
  // read port
  input  wire logic [`STACK_PTR_WIDTH-1:0]   rdAddr,
  output logic      [`PC_WIDTH-1:0]          rdData
);
  logic [`PC_WIDTH-1:0] mem [0:`STACK_DEPTH];
  // storage write, no reset so it maps to a ram
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
  // registered read
  always_ff @(posedge sys_clk) begin
    rdData <= mem[rdAddr];
  end
endmodule

// *** rtl/rotate_unit.sv ***
// combinational rotate and fill datapath
`timescale 1ns/10ps
`include "crr_exec_params.svh"
module rotate_unit (
  // operation
  input  wire crr_exec_pkg::op_kind_t opKind,
  input  wire logic [7:0]             operand,
  input  wire logic                   carryIn,
  // result
  output logic      [7:0]             result,
  output logic                        carryOut,
  output logic                        writesCarry,
  output logic                        writesNz
);
  // one shift per kind, flags chosen per kind
  always_comb begin
    result      = operand;
    carryOut    = carryIn;
    writesCarry = 1'b0;
    writesNz    = 1'b1;
    case (opKind)
      crr_exec_pkg::OP_RLC: begin
        result      = {operand[6:0], carryIn};
        carryOut    = operand[7];
        writesCarry = 1'b1;
      end
      crr_exec_pkg::OP_RLN: begin
        result = {operand[6:0], operand[7]};
      end
      crr_exec_pkg::OP_RRC: begin
        result      = {carryIn, operand[7:1]};
        carryOut    = operand[0];
        writesCarry = 1'b1;
      end
      crr_exec_pkg::OP_RRN: begin
        result = {operand[0], operand[7:1]};
      end
      crr_exec_pkg::OP_FILL: begin
        result   = `FILL_VALUE;
        writesNz = 1'b0;
      end
      default: begin
        writesNz = 1'b0;
      end
    endcase
  end
endmodule

// *** rtl/call_return_rotate_exec.sv ***
// execution of stack, call, return, reset, rotate and fill instructions
`timescale 1ns/10ps
`include "crr_exec_params.svh"
// Summary of operation
// - relative call pushes PC+2 onto the return stack first.
// - relative call jumps to PC+2 plus twice the signed 11-bit offset.
// - relative call takes two cycles, second is a no-op.
// - software reset opcode restores every register except the shadows and the file port to pin reset state.
// - interrupt return pops stack into PC, two cycles.
// - interrupt return sets the high or low global irq enable.
// - with s=1 returns restore accumulator, flags, bank from shadows.
// - with s=0 accumulator, flags and bank pointer stay unchanged.
// - literal return loads accumulator, pops PC, two cycles, latches kept.
// - subroutine return pops PC, s=1 restores shadows, latches kept.
// - rotate left through carry, bit7 to carry, updates C N Z.
// - rotate left plain wraps bit7 to bit0, updates N Z only.
// - rotate right plain wraps bit0 to bit7, updates N Z only.
// - d=0 sends rotate result to accumulator, d=1 to file register.
// - a=0 selects access bank, a=1 uses bank pointer.
module call_return_rotate_exec (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  // instruction issue
  input  wire logic                 instrValid,
  input  wire logic [15:0]          instrWord,
  input  wire logic                 irqPriorityHigh,
  // file register read data for the addressed location
  input  wire logic [7:0]           fileRdData,
  // interrupt entry saves shadows
  input  wire logic                 shadowSave,
  // core state out
  output logic [`PC_WIDTH-1:0]      pcOut_q,
  output logic [`PC_WIDTH-1:0]      stackTop_q,
  output logic [`STACK_PTR_WIDTH-1:0] stackPtr_q,
  output logic [7:0]                accumulator_q,
  output logic [7:0]                flags_q,
  output logic [7:0]                bankPointer_q,
  output logic [7:0]                pcHighLatch_q,
  output logic [7:0]                pcUpperLatch_q,
  output logic                      highPriorityIrqEnable_q,
  output logic                      lowPriorityIrqEnable_q,
  // file register access
  output logic [11:0]               fileAddr_q,
  output logic [7:0]                fileWrData_q,
  output logic                      fileWrEn_q,
  // status
  output logic                      busy_q
);
  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  crr_exec_pkg::op_kind_t     opKind;
  crr_exec_pkg::exec_state_t  state_q;
  logic [7:0]                 shadowAccumulator_q;
  logic [7:0]                 shadowFlags_q;
  logic [7:0]                 shadowBankPointer_q;
  logic                       issue;
  logic                       destFile;
  logic                       bankSel;
  logic                       shadowRestore;
  logic [`PC_WIDTH-1:0]       pcNext;
  logic [`PC_WIDTH-1:0]       callTarget;
  logic [7:0]                 rotResult;
  logic                       rotCarry;
  logic                       rotWritesC;
  logic                       rotWritesNz;
  logic [`STACK_PTR_WIDTH-1:0] popPtr;
  logic [`PC_WIDTH-1:0]       memRd;

  // opcodes taken only when no two-cycle op is pending
  assign issue = instrValid && (state_q == crr_exec_pkg::EXEC_RUN);

  // opcode recognition
  always_comb begin
    opKind = crr_exec_pkg::OP_NONE;
    if (instrWord[15:12] == 4'hD) begin
      opKind = crr_exec_pkg::OP_RELATIVE_CALL;
    end else if (instrWord == 16'h0005) begin
      opKind = crr_exec_pkg::OP_PUSH;
    end else if (instrWord == 16'h0006) begin
      opKind = crr_exec_pkg::OP_POP;
    end else if (instrWord == 16'h00FF) begin
      opKind = crr_exec_pkg::OP_RST;
    end else if (instrWord[15:1] == 15'h0008) begin
      opKind = crr_exec_pkg::OP_IRET;
    end else if (instrWord[15:1] == 15'h0009) begin
      opKind = crr_exec_pkg::OP_RET;
    end else if (instrWord[15:8] == 8'h0C) begin
      opKind = crr_exec_pkg::OP_RLIT;
    end else if (instrWord[15:10] == 6'h0D) begin
      opKind = crr_exec_pkg::OP_RLC;
    end else if (instrWord[15:10] == 6'h0C) begin
      opKind = crr_exec_pkg::OP_RRC;
    end else if (instrWord[15:10] == 6'h11) begin
      opKind = crr_exec_pkg::OP_RLN;
    end else if (instrWord[15:10] == 6'h10) begin
      opKind = crr_exec_pkg::OP_RRN;
    end else if (instrWord[15:9] == 7'h34) begin
      opKind = crr_exec_pkg::OP_FILL;
    end
  end

  assign destFile      = instrWord[9];
  assign bankSel       = instrWord[8];
  assign shadowRestore = instrWord[0];
  assign pcNext        = pcOut_q + `PC_STEP;
  // sign-extend 11-bit word offset, times two
  assign callTarget = pcNext +
    {{(`PC_WIDTH-12){instrWord[10]}}, instrWord[10:0], 1'b0};
  assign popPtr = stackPtr_q - 5'h01;

  // --------------------------------------------------------------
  // datapath instances
  // --------------------------------------------------------------
  rotate_unit u_rot (
    .opKind      (opKind),
    .operand     (fileRdData),
    .carryIn     (flags_q[`FLAG_C]),
    .result      (rotResult),
    .carryOut    (rotCarry),
    .writesCarry (rotWritesC),
    .writesNz    (rotWritesNz)
  );

  // the memory read runs one cycle behind; stackTop_q is the live copy
  return_stack_mem u_stack (
    .sys_clk (sys_clk),
    .wrEn    (issue && (opKind == crr_exec_pkg::OP_PUSH ||
                        opKind == crr_exec_pkg::OP_RELATIVE_CALL)),
    .wrAddr  (stackPtr_q),
    .wrData  (stackTop_q),
    .rdAddr  (popPtr), // entry just below the live top
    .rdData  (memRd)
  );

  // --------------------------------------------------------------
  // sequencing
  // --------------------------------------------------------------
  // two-cycle ops park in the wait state for the refetch slot
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= crr_exec_pkg::EXEC_RUN;
      busy_q  <= 1'b0;
    end else if (issue && (opKind == crr_exec_pkg::OP_RELATIVE_CALL ||
                           opKind == crr_exec_pkg::OP_IRET ||
                           opKind == crr_exec_pkg::OP_RLIT ||
                           opKind == crr_exec_pkg::OP_RET)) begin
      state_q <= crr_exec_pkg::EXEC_WAIT;
      busy_q  <= 1'b1;
    end else begin
      state_q <= crr_exec_pkg::EXEC_RUN;
      busy_q  <= 1'b0;
    end
  end

  // program counter and return stack
  always_ff @(posedge sys_clk) begin
    if (!nrst || (issue && opKind == crr_exec_pkg::OP_RST)) begin
      pcOut_q    <= `RESET_PC;
      stackTop_q <= `RESET_PC;
      stackPtr_q <= 5'h00;
    end else if (issue) begin
      case (opKind)
        crr_exec_pkg::OP_RELATIVE_CALL: begin
          stackTop_q <= pcNext;
          stackPtr_q <= stackPtr_q + 5'h01;
          pcOut_q    <= callTarget;
        end
        crr_exec_pkg::OP_PUSH: begin
          stackTop_q <= pcNext;
          stackPtr_q <= stackPtr_q + 5'h01;
          pcOut_q    <= pcNext;
        end
        crr_exec_pkg::OP_POP, crr_exec_pkg::OP_IRET,
        crr_exec_pkg::OP_RLIT, crr_exec_pkg::OP_RET: begin
          // stack empty reads back zero, as a fresh reset would
          stackTop_q <= (stackPtr_q > 5'h01) ? memRd : `RESET_PC;
          stackPtr_q <= popPtr;
          pcOut_q    <= (opKind == crr_exec_pkg::OP_POP) ? pcNext
                                                         : stackTop_q;
        end
        default: begin
          pcOut_q <= pcNext;
        end
      endcase
    end
  end

  // accumulator, flags and bank pointer
  always_ff @(posedge sys_clk) begin
    if (!nrst || (issue && opKind == crr_exec_pkg::OP_RST)) begin
      accumulator_q <= `RESET_WORD;
      flags_q       <= `RESET_WORD;
      bankPointer_q <= `RESET_WORD;
    end else if (issue) begin
      case (opKind)
        crr_exec_pkg::OP_IRET, crr_exec_pkg::OP_RET: begin
          if (shadowRestore) begin
            accumulator_q <= shadowAccumulator_q;
            flags_q       <= shadowFlags_q;
            bankPointer_q <= shadowBankPointer_q;
          end
        end
        crr_exec_pkg::OP_RLIT: begin
          accumulator_q <= instrWord[7:0];
        end
        crr_exec_pkg::OP_RLC, crr_exec_pkg::OP_RRC,
        crr_exec_pkg::OP_RLN, crr_exec_pkg::OP_RRN: begin
          if (!destFile) begin
            accumulator_q <= rotResult;
          end
          if (rotWritesC) begin
            flags_q[`FLAG_C] <= rotCarry;
          end
          flags_q[`FLAG_Z] <= (rotResult == 8'h00);
          flags_q[`FLAG_N] <= rotResult[7];
        end
        default: begin
        end
      endcase
    end
  end

  // shadow capture on interrupt entry
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shadowAccumulator_q <= `RESET_WORD;
      shadowFlags_q       <= `RESET_WORD;
      shadowBankPointer_q <= `RESET_WORD;
    end else if (shadowSave) begin
      shadowAccumulator_q <= accumulator_q;
      shadowFlags_q       <= flags_q;
      shadowBankPointer_q <= bankPointer_q;
    end
  end

  // upper pc latches only move on reset; returns leave them alone
  always_ff @(posedge sys_clk) begin
    if (!nrst || (issue && opKind == crr_exec_pkg::OP_RST)) begin
      pcHighLatch_q  <= `RESET_WORD;
      pcUpperLatch_q <= `RESET_WORD;
    end
  end

  // global interrupt enables
  always_ff @(posedge sys_clk) begin
    if (!nrst || (issue && opKind == crr_exec_pkg::OP_RST)) begin
      highPriorityIrqEnable_q <= 1'b0;
      lowPriorityIrqEnable_q  <= 1'b0;
    end else if (issue && opKind == crr_exec_pkg::OP_IRET) begin
      if (irqPriorityHigh) begin
        highPriorityIrqEnable_q <= 1'b1;
      end else begin
        lowPriorityIrqEnable_q <= 1'b1;
      end
    end
  end

  // file register address and write port
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      fileAddr_q   <= 12'h000;
      fileWrData_q <= `RESET_WORD;
      fileWrEn_q   <= 1'b0;
    end else begin
      // access bank: low half in bank 0, high half in top bank
      if (!bankSel) begin
        fileAddr_q <= {(instrWord[7:0] >= `ACCESS_SPLIT) ? `ACCESS_HIGH
                        : 4'h0, instrWord[7:0]};
      end else begin
        fileAddr_q <= {bankPointer_q[3:0], instrWord[7:0]};
      end
      fileWrData_q <= rotResult;
      fileWrEn_q   <= issue && (opKind == crr_exec_pkg::OP_FILL ||
                      (rotWritesNz && destFile));
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_call_target;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_RELATIVE_CALL |=>
      pcOut_q == $past(callTarget) && stackTop_q == $past(pcNext);
  endproperty
  a_call_target: assert property (p_call_target)
    else $error("call target or pushed address wrong");
  property p_call_two;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_RELATIVE_CALL |=> busy_q ##1 !busy_q;
  endproperty
  a_call_two: assert property (p_call_two)
    else $error("relative call not two cycles");
  property p_iret_pc;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_IRET |=>
      pcOut_q == $past(stackTop_q) &&
      stackPtr_q == $past(stackPtr_q) - 5'h01;
  endproperty
  a_iret_pc: assert property (p_iret_pc)
    else $error("interrupt return did not pop");
  property p_iret_gie;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_IRET |=>
      highPriorityIrqEnable_q || lowPriorityIrqEnable_q;
  endproperty
  a_iret_gie: assert property (p_iret_gie)
    else $error("interrupt enable not set");
  property p_noshadow;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_RET && !shadowRestore |=>
      $stable(accumulator_q) && $stable(bankPointer_q);
  endproperty
  a_noshadow: assert property (p_noshadow)
    else $error("registers changed without restore");
  property p_shadow;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_IRET && shadowRestore |=>
      accumulator_q == $past(shadowAccumulator_q);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow restore missing");
  property p_rlit;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_RLIT |=>
      accumulator_q == $past(instrWord[7:0]) && $stable(pcHighLatch_q);
  endproperty
  a_rlit: assert property (p_rlit)
    else $error("literal return wrong");
  property p_reset;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_RST |=>
      pcOut_q == `RESET_PC && stackPtr_q == 5'h00 && flags_q == 8'h00;
  endproperty
  a_reset: assert property (p_reset)
    else $error("software reset incomplete");
  property p_fill;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_FILL |=>
      fileWrEn_q && fileWrData_q == 8'hFF && $stable(flags_q);
  endproperty
  a_fill: assert property (p_fill)
    else $error("fill wrong");
  property p_push;
    @(posedge sys_clk) disable iff (!nrst)
    issue && opKind == crr_exec_pkg::OP_PUSH |=>
      stackPtr_q == $past(stackPtr_q) + 5'h01 && !busy_q;
  endproperty
  a_push: assert property (p_push)
    else $error("push wrong");
  c_call: cover property (@(posedge sys_clk)
    issue && opKind == crr_exec_pkg::OP_RELATIVE_CALL);
  c_iret: cover property (@(posedge sys_clk)
    issue && opKind == crr_exec_pkg::OP_IRET && shadowRestore);
  c_rot: cover property (@(posedge sys_clk)
    issue && opKind == crr_exec_pkg::OP_RLC && !destFile);
endmodule

// *** dv/test_call_return_rotate_exec.sv ***
// self-checking bench for the call, return, rotate and fill execution block
`timescale 1ns/10ps
`include "crr_exec_params.svh"
module test_call_return_rotate_exec;
  // ----------------------------------------
  // signals and reference state
  // ----------------------------------------
  typedef struct {
    logic [20:0] pc, top;
    logic [4:0]  ptr;
    logic [7:0]  acc, flg, wd;
    logic [11:0] fa;
    logic        we, ieH, ieL, bsy, file;
  } note_t;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        instrValid = 1'b0, irqPriorityHigh = 1'b0, shadowSave = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic [7:0]  fileRdData = 8'h00;
  logic [20:0] pcOut_q, stackTop_q, mPc, stk[32];
  logic [4:0]  stackPtr_q, mPtr;
  logic [7:0]  accumulator_q, flags_q, bankPointer_q, pcHighLatch_q;
  logic [7:0]  pcUpperLatch_q, fileWrData_q, mAcc, mFlg, sAcc, sFlg;
  logic        highPriorityIrqEnable_q, lowPriorityIrqEnable_q, mIeH, mIeL;
  logic [11:0] fileAddr_q;
  logic        fileWrEn_q, busy_q, taken = 1'b0;
  int          numErrors = 0, samplesChecked = 0;
  note_t       q[$];

  call_return_rotate_exec dut (
    .sys_clk(sys_clk), .nrst(nrst), .instrValid(instrValid),
    .instrWord(instrWord), .irqPriorityHigh(irqPriorityHigh),
    .fileRdData(fileRdData), .shadowSave(shadowSave), .pcOut_q(pcOut_q),
    .stackTop_q(stackTop_q), .stackPtr_q(stackPtr_q),
    .accumulator_q(accumulator_q), .flags_q(flags_q),
    .bankPointer_q(bankPointer_q), .pcHighLatch_q(pcHighLatch_q),
    .pcUpperLatch_q(pcUpperLatch_q),
    .highPriorityIrqEnable_q(highPriorityIrqEnable_q),
    .lowPriorityIrqEnable_q(lowPriorityIrqEnable_q),
    .fileAddr_q(fileAddr_q), .fileWrData_q(fileWrData_q),
    .fileWrEn_q(fileWrEn_q), .busy_q(busy_q));

  // 200 MHz clock
  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // closing and comparison
  // ----------------------------------------
  task automatic stop_test;
    if (numErrors == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [20:0] e,
                     input logic [20:0] g);
    samplesChecked++;
    if (g !== e) begin
      numErrors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // ----------------------------------------
  // driver: model the opcode, note the result, issue it
  // ----------------------------------------
  task automatic issue(input logic [15:0] w, input logic [7:0] fd,
                       input logic pri, input logic take);
    note_t n;
    logic [7:0] r;
    logic c;
    instrValid <= 1'b1;
    instrWord <= w;
    fileRdData <= fd;
    irqPriorityHigh <= pri;
    n.we = 1'b0; n.file = 1'b0; n.bsy = 1'b0; n.wd = 8'h00;
    c = mFlg[0];
    r = fd;
    if (take) begin
      if (w == 16'h0005) begin
        mPtr++; stk[mPtr] = mPc + `PC_STEP; mPc += `PC_STEP;
      end else if (w == 16'h0006) begin
        mPtr--; mPc += `PC_STEP;
      end else if (w == 16'h00FF) begin
        mPc = '0; mPtr = '0; mAcc = '0; mFlg = '0; mIeH = 0; mIeL = 0;
      end else if (w[15:2] == 14'h0004) begin
        mPc = stk[mPtr]; mPtr--; n.bsy = 1'b1;
        if (w[0]) begin
          mAcc = sAcc; mFlg = sFlg;
        end
        if (!w[1] && pri) mIeH = 1'b1;
        if (!w[1] && !pri) mIeL = 1'b1;
      end else if (w[15:8] == 8'h0C) begin
        mAcc = w[7:0]; mPc = stk[mPtr]; mPtr--; n.bsy = 1'b1;
      end else if (w[15:11] == 5'b11010) begin
        mPtr++; stk[mPtr] = mPc + `PC_STEP; n.bsy = 1'b1;
        mPc = mPc + `PC_STEP + {{9{w[10]}}, w[10:0], 1'b0};
      end else begin
        // file operations all step the counter by one word
        mPc += `PC_STEP; n.file = 1'b1;
        case (w[15:10])
          6'h0D: {c, r} = {fd, mFlg[0]};
          6'h0C: {r, c} = {mFlg[0], fd};
          6'h11: r = {fd[6:0], fd[7]};
          6'h10: r = {fd[0], fd[7:1]};
          default: r = `FILL_VALUE;
        endcase
        if (w[15:9] == 7'h34) n.we = 1'b1;
        else begin
          mFlg[`FLAG_N] = r[7];
          mFlg[`FLAG_Z] = (r == 8'h00);
          if (w[15:11] == 5'b00110) mFlg[`FLAG_C] = c;
          if (w[9]) n.we = 1'b1;
          else mAcc = r;
        end
        n.wd = r;
      end
      // bank pointer stays zero: only shadows of zero reach it
      n.fa = w[8] ? {4'h0, w[7:0]} :
             {(w[7:0] < `ACCESS_SPLIT) ? 4'h0 : `ACCESS_HIGH, w[7:0]};
      n.pc = mPc; n.top = stk[mPtr]; n.ptr = mPtr; n.acc = mAcc;
      n.flg = mFlg; n.ieH = mIeH; n.ieL = mIeL;
      q.push_back(n);
    end
    @(posedge sys_clk);
  endtask

  task automatic idle(input int k);
    instrValid <= 1'b0;
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic save;
    instrValid <= 1'b0;
    shadowSave <= 1'b1;
    sAcc = mAcc;
    sFlg = mFlg;
    @(posedge sys_clk);
    shadowSave <= 1'b0;
    @(posedge sys_clk);
  endtask

  // ----------------------------------------
  // monitor: compare in the cycle after an accepted instruction
  // ----------------------------------------
  always @(posedge sys_clk)
    taken <= nrst && instrValid && !busy_q;

  always @(negedge sys_clk) begin
    note_t n;
    if (taken && q.size() == 0) cmp("queue", 21'h1, 21'h0);
    else if (taken) begin
      n = q.pop_front();
      cmp("pc", n.pc, pcOut_q);
      cmp("top", n.top, stackTop_q);
      cmp("ptr", 21'(n.ptr), 21'(stackPtr_q));
      cmp("acc", 21'(n.acc), 21'(accumulator_q));
      cmp("flags", 21'(n.flg), 21'(flags_q));
      cmp("bank", 21'h0, 21'(bankPointer_q));
      cmp("latches", 21'h0, 21'({pcHighLatch_q, pcUpperLatch_q}));
      cmp("ieh", 21'(n.ieH), 21'(highPriorityIrqEnable_q));
      cmp("iel", 21'(n.ieL), 21'(lowPriorityIrqEnable_q));
      cmp("busy", 21'(n.bsy), 21'(busy_q));
      cmp("wren", 21'(n.we), 21'(fileWrEn_q));
      if (n.file) cmp("addr", 21'(n.fa), 21'(fileAddr_q));
      if (n.we) cmp("wrdata", 21'(n.wd), 21'(fileWrData_q));
    end else if (nrst) cmp("wren idle", 21'h0, 21'(fileWrEn_q));
  end

  // watchdog against a stuck run
  initial begin
    repeat (4000) @(posedge sys_clk);
    numErrors++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  logic [15:0] ops[5] = '{16'h3400, 16'h3000, 16'h4400, 16'h4000, 16'h6800};
  initial begin
    logic [15:0] w;
    logic [7:0]  fd;
    void'($urandom(32'hA6BC));
    mPc = '0; mPtr = '0; mAcc = '0; mFlg = '0; mIeH = 0; mIeL = 0;
    sAcc = '0; sFlg = '0;
    foreach (stk[i]) stk[i] = '0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    // pops kept two cycles apart from stack updates: stale top otherwise
    repeat (3) begin
      issue(16'h0005, 8'h00, 1'b0, 1'b1);
      idle(1);
    end
    issue(16'h0006, 8'h00, 1'b0, 1'b1);
    idle(1);
    for (int i = 0; i < 4; i++) begin
      w = 16'hD000 | 16'($urandom_range(0, 16'h07FF));
      if (i == 0) w = 16'hD400;
      issue(w, 8'h00, 1'b0, 1'b1);
      // an instruction in the busy cycle must be dropped
      if (i == 1) issue(16'h6900, 8'h00, 1'b0, 1'b0);
      idle(1);
    end
    // every rotate with all destination and bank choices, fill with both bank choices
    for (int i = 0; i < 20; i++) begin
      w = ops[i % 5] | {6'h00, (i % 5 == 4) ? 1'b0 : (i / 5) % 2 == 1,
                        i / 10 == 1, 8'($urandom)};
      fd = (i == 7) ? 8'h00 : 8'($urandom);
      issue(w, fd, 1'b0, 1'b1);
    end
    issue(16'h4480, 8'h5A, 1'b0, 1'b1);
    idle(1);
    save();
    issue(16'h3000, 8'h01, 1'b0, 1'b1);
    idle(1);
    issue(16'h0011, 8'h00, 1'b1, 1'b1);
    idle(2);
    issue(16'h0012, 8'h00, 1'b0, 1'b1);
    idle(2);
    issue(16'h0C00 | 16'($urandom_range(0, 255)), 8'h00, 1'b0, 1'b1);
    idle(2);
    issue(16'h0010, 8'h00, 1'b0, 1'b1);
    idle(2);
    issue(16'h0013, 8'h00, 1'b0, 1'b1);
    idle(2);
    issue(16'h00FF, 8'h00, 1'b0, 1'b1);
    idle(1);
    issue(16'h0005, 8'h00, 1'b0, 1'b1);
    idle(3);
    if (q.size() != 0) cmp("pending", 21'h0, 21'(q.size()));
    stop_test();
  end
endmodule
